// [ops_pkg.sv]
// Shared constants and types for the operation/power status groups.
// Assumes a single 125 MHz core clock and a synchronous active-high reset.
package ops_pkg;

	// ------------------------------------------------------------------
	// Widths and sizes
	// ------------------------------------------------------------------
	localparam int REG_W = 16;
	localparam int OQ_DEPTH = 16;
	localparam int TEMP_W = 12;
	localparam int TEMP_LIMIT_C = 10;

	// ------------------------------------------------------------------
	// Group indices
	// ------------------------------------------------------------------
	localparam int GRP_OPER = 0;
	localparam int GRP_POW = 1;
	localparam int GRP_N = 2;

	// ------------------------------------------------------------------
	// Operation condition bit positions
	// ------------------------------------------------------------------
	localparam int OPER_CALIBRATING = 0;
	localparam int OPER_RANGING_ERR = 2;
	localparam int OPER_MEASURING = 4;
	localparam int OPER_PRIMARY_RADIO = 8;
	localparam int OPER_CALL_PROC = 9;
	localparam int OPER_SECONDARY_RADIO = 10;
	localparam int OPER_EMBEDDED_SUM = 11;
	localparam int OPER_EXT_TIMEBASE = 12;
	localparam int OPER_PROG_RUNNING = 14;

	// ------------------------------------------------------------------
	// Power condition bit positions
	// ------------------------------------------------------------------
	localparam int POW_FREQ_UNCAL = 0;
	localparam int POW_BELOW_TEMP = 1;
	localparam int POW_ABOVE_TEMP = 2;

	// ------------------------------------------------------------------
	// Implemented condition bits and reset values
	// ------------------------------------------------------------------
	localparam logic [REG_W-1:0] OPER_COND_MASK = 16'h5F11;
	localparam logic [REG_W-1:0] POW_COND_MASK = 16'h0007;
	localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
	localparam logic [REG_W-1:0] RISE_RESET = 16'hFFFF;
	localparam logic [REG_W-1:0] FALL_RESET = 16'h0000;

	// ------------------------------------------------------------------
	// Command set of the status query port
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		OPS_READ_COND,
		OPS_READ_RISE,
		OPS_WRITE_RISE,
		OPS_READ_FALL,
		OPS_WRITE_FALL,
		OPS_READ_EVENT,
		OPS_READ_MASK,
		OPS_WRITE_MASK,
		OPS_CLEAR_STATUS
	} ops_cmd_t;

	typedef struct packed {
		ops_cmd_t op;
		logic group;
		logic [REG_W-1:0] data;
	} ops_request_t;

	typedef struct packed {
		logic [REG_W-1:0] cond_prev;
		logic [REG_W-1:0] rising_filter;
		logic [REG_W-1:0] falling_filter;
		logic [REG_W-1:0] event_latch;
		logic [REG_W-1:0] event_mask;
	} ops_group_t;

endpackage

// [ops_status.sv]
// Operation and power-calibration status register groups with the output
// queue and its message-available summary, plus the queue FIFO itself.
// Assumes all inputs are synchronous to core_clk; the bus parser in front
// delivers decoded status commands and other response words.

// ----------------------------------------------------------------------
// Output queue FIFO
// ----------------------------------------------------------------------
module ops_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int PW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [LW-1:0] count;
	} ops_fifo_state_t;

	ops_fifo_state_t s_reg;
	ops_fifo_state_t s_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	assign in_ready = (s_reg.count != LW'(DEPTH));
	assign out_valid = (s_reg.count != '0);
	assign out_data = mem[s_reg.rd_ptr];
	assign level = s_reg.count;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.wr_ptr = (s_reg.wr_ptr == PW'(DEPTH - 1)) ? '0 :
				s_reg.wr_ptr + PW'(1);
		end
		if (pop) begin
			s_next.rd_ptr = (s_reg.rd_ptr == PW'(DEPTH - 1)) ? '0 :
				s_reg.rd_ptr + PW'(1);
		end
		if (push && !pop) begin
			s_next.count = s_reg.count + LW'(1);
		end else if (pop && !push) begin
			s_next.count = s_reg.count - LW'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Storage has no reset; only words below count are ever read.
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[s_reg.wr_ptr] <= in_data;
		end
	end
endmodule // ops_fifo

// ----------------------------------------------------------------------
// Status groups and queue front end
// ----------------------------------------------------------------------
module ops_status #(
	parameter int OQ_DEPTH = ops_pkg::OQ_DEPTH,
	parameter int TEMP_W = ops_pkg::TEMP_W
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire ops_pkg::ops_request_t cmd,
	input wire logic resp_valid,
	output logic resp_ready,
	input wire logic [ops_pkg::REG_W-1:0] resp_data,
	output logic oq_valid,
	input wire logic oq_ready,
	output logic [ops_pkg::REG_W-1:0] oq_data,
	input wire logic prog_running,
	input wire logic ext_timebase,
	input wire logic primary_radio_summary,
	input wire logic call_proc_summary,
	input wire logic secondary_radio_summary,
	input wire logic embedded_program_summary,
	input wire logic measuring_summary,
	input wire logic calibrating_summary,
	input wire logic ranging_error,
	input wire logic signed [TEMP_W-1:0] meas_temp,
	input wire logic signed [TEMP_W-1:0] cal_temp,
	input wire logic freq_uncal,
	output logic operation_summary,
	output logic message_available,
	output logic ques_power_summary
);
	localparam int W = ops_pkg::REG_W;
	localparam int LW = $clog2(OQ_DEPTH+1);

	typedef struct packed {
		ops_pkg::ops_group_t [ops_pkg::GRP_N-1:0] grp;
		logic cmd_ready;
		logic resp_ready;
		logic oq_valid;
		logic [W-1:0] oq_data;
		logic msg_avail;
		logic oper_sum;
		logic pow_sum;
	} ops_state_t;

	ops_state_t s_reg;
	ops_state_t s_next;
	logic [W-1:0] cond [ops_pkg::GRP_N];
	logic signed [TEMP_W:0] temp_diff;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [W-1:0] fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [W-1:0] fifo_out_data;
	logic [LW-1:0] fifo_level;
	logic cmd_fire;
	logic query_push;
	logic resp_push;
	logic [W-1:0] query_data;
	logic [ops_pkg::GRP_N-1:0] ev_clear;
	logic [ops_pkg::GRP_N-1:0] sum_next;
	logic queue_idle;

	// ------------------------------------------------------------------
	// Condition sources
	// ------------------------------------------------------------------
	// The difference is one bit wider so extreme readings cannot wrap.
	assign temp_diff = (TEMP_W+1)'(meas_temp) - (TEMP_W+1)'(cal_temp);

	always_comb begin
		cond[ops_pkg::GRP_OPER] = '0;
		cond[ops_pkg::GRP_OPER][ops_pkg::OPER_PROG_RUNNING] = prog_running;
		cond[ops_pkg::GRP_OPER][ops_pkg::OPER_EXT_TIMEBASE] = ext_timebase;
		cond[ops_pkg::GRP_OPER][ops_pkg::OPER_PRIMARY_RADIO] =
			primary_radio_summary;
		cond[ops_pkg::GRP_OPER][ops_pkg::OPER_CALL_PROC] =
			call_proc_summary;
		cond[ops_pkg::GRP_OPER][ops_pkg::OPER_SECONDARY_RADIO] =
			secondary_radio_summary;
		cond[ops_pkg::GRP_OPER][ops_pkg::OPER_EMBEDDED_SUM] =
			embedded_program_summary;
		cond[ops_pkg::GRP_OPER][ops_pkg::OPER_MEASURING] =
			measuring_summary;
		cond[ops_pkg::GRP_OPER][ops_pkg::OPER_CALIBRATING] =
			calibrating_summary;
		cond[ops_pkg::GRP_POW] = '0;
		cond[ops_pkg::GRP_POW][ops_pkg::POW_ABOVE_TEMP] =
			temp_diff > (TEMP_W+1)'(ops_pkg::TEMP_LIMIT_C);
		cond[ops_pkg::GRP_POW][ops_pkg::POW_BELOW_TEMP] =
			temp_diff < -(TEMP_W+1)'(ops_pkg::TEMP_LIMIT_C);
		cond[ops_pkg::GRP_POW][ops_pkg::POW_FREQ_UNCAL] = freq_uncal;
		// Masking keeps bit 15 and every unused bit at zero.
		cond[ops_pkg::GRP_OPER] =
			cond[ops_pkg::GRP_OPER] & ops_pkg::OPER_COND_MASK;
		cond[ops_pkg::GRP_POW] =
			cond[ops_pkg::GRP_POW] & ops_pkg::POW_COND_MASK;
	end

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	assign cmd_fire = cmd_valid & s_reg.cmd_ready;

	always_comb begin
		query_push = 1'b0;
		query_data = '0;
		ev_clear = '0;
		if (cmd_fire) begin
			unique case (cmd.op)
				ops_pkg::OPS_READ_COND: begin
					query_push = 1'b1;
					query_data = cond[cmd.group];
				end
				ops_pkg::OPS_READ_RISE: begin
					query_push = 1'b1;
					query_data = s_reg.grp[cmd.group].rising_filter;
				end
				ops_pkg::OPS_READ_FALL: begin
					query_push = 1'b1;
					query_data = s_reg.grp[cmd.group].falling_filter;
				end
				ops_pkg::OPS_READ_EVENT: begin
					query_push = 1'b1;
					query_data = s_reg.grp[cmd.group].event_latch;
					ev_clear[cmd.group] = 1'b1;
				end
				ops_pkg::OPS_READ_MASK: begin
					query_push = 1'b1;
					query_data = s_reg.grp[cmd.group].event_mask;
				end
				ops_pkg::OPS_CLEAR_STATUS: begin
					ev_clear = '1;
				end
				ops_pkg::OPS_WRITE_RISE, ops_pkg::OPS_WRITE_FALL,
				ops_pkg::OPS_WRITE_MASK: begin
				end
				default: begin
				end
			endcase
		end
	end

	// Query answers and other responses never share a cycle because their
	// ready flags are made mutually exclusive below.
	assign resp_push = resp_valid & s_reg.resp_ready;
	assign fifo_in_valid = query_push | resp_push;
	assign fifo_in_data = query_push ? query_data : resp_data;
	assign fifo_out_ready = ~s_reg.oq_valid | oq_ready;
	assign queue_idle = (fifo_level == '0) & ~s_reg.oq_valid & ~fifo_in_valid;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		for (int g = 0; g < ops_pkg::GRP_N; g++) begin
			s_next.grp[g].cond_prev = cond[g];
			// Set wins over clear: an edge in the clearing cycle survives.
			s_next.grp[g].event_latch =
				(ev_clear[g] ? '0 : s_reg.grp[g].event_latch) |
				(cond[g] & ~s_reg.grp[g].cond_prev &
				s_reg.grp[g].rising_filter) |
				(~cond[g] & s_reg.grp[g].cond_prev &
				s_reg.grp[g].falling_filter);
			sum_next[g] = |(s_next.grp[g].event_latch &
				s_reg.grp[g].event_mask);
		end
		if (ranging_error) begin
			s_next.grp[ops_pkg::GRP_OPER].event_latch[ops_pkg::OPER_RANGING_ERR] =
				1'b1;
		end
		if (cmd_fire) begin
			unique case (cmd.op)
				ops_pkg::OPS_WRITE_RISE: begin
					s_next.grp[cmd.group].rising_filter = cmd.data;
				end
				ops_pkg::OPS_WRITE_FALL: begin
					s_next.grp[cmd.group].falling_filter = cmd.data;
				end
				ops_pkg::OPS_WRITE_MASK: begin
					s_next.grp[cmd.group].event_mask = cmd.data;
				end
				default: begin
				end
			endcase
		end
		sum_next[ops_pkg::GRP_OPER] = |(s_next.grp[ops_pkg::GRP_OPER].event_latch &
			s_reg.grp[ops_pkg::GRP_OPER].event_mask);
		s_next.oper_sum = sum_next[ops_pkg::GRP_OPER];
		s_next.pow_sum = sum_next[ops_pkg::GRP_POW];
		if (fifo_out_valid && fifo_out_ready) begin
			s_next.oq_valid = 1'b1;
			s_next.oq_data = fifo_out_data;
		end else if (oq_ready) begin
			s_next.oq_valid = 1'b0;
		end
		s_next.msg_avail = s_next.oq_valid | fifo_out_valid;
		// Commands wait until every queued word has been taken.
		s_next.cmd_ready = queue_idle & ~resp_valid;
		// Three free slots cover the words that may land while this flag lags.
		s_next.resp_ready = ~s_next.cmd_ready & fifo_in_ready &
			(fifo_level < LW'(OQ_DEPTH - 2));
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int g = 0; g < ops_pkg::GRP_N; g++) begin
				s_reg.grp[g].cond_prev <= ops_pkg::REG_RESET;
				s_reg.grp[g].rising_filter <= ops_pkg::RISE_RESET;
				s_reg.grp[g].falling_filter <= ops_pkg::FALL_RESET;
				s_reg.grp[g].event_latch <= ops_pkg::REG_RESET;
				s_reg.grp[g].event_mask <= ops_pkg::REG_RESET;
			end
			s_reg.cmd_ready <= 1'b0;
			s_reg.resp_ready <= 1'b0;
			s_reg.oq_valid <= 1'b0;
			s_reg.oq_data <= '0;
			s_reg.msg_avail <= 1'b0;
			s_reg.oper_sum <= 1'b0;
			s_reg.pow_sum <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------------
	// Queue and outputs
	// ------------------------------------------------------------------
	ops_fifo #(
		.WIDTH(W),
		.DEPTH(OQ_DEPTH)
	) ops_fifo_inst (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	assign cmd_ready = s_reg.cmd_ready;
	assign resp_ready = s_reg.resp_ready;
	assign oq_valid = s_reg.oq_valid;
	assign oq_data = s_reg.oq_data;
	assign operation_summary = s_reg.oper_sum;
	assign message_available = s_reg.msg_avail;
	assign ques_power_summary = s_reg.pow_sum;
endmodule // ops_status

// [ops_status_monitor.sv]
// Concurrent checks on the status block, watching its top-level ports.
// Assumes one clock domain with a synchronous active-high reset.
module ops_status_monitor (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire ops_pkg::ops_request_t cmd,
	input wire logic resp_ready,
	input wire logic oq_valid,
	input wire logic oq_ready,
	input wire logic [ops_pkg::REG_W-1:0] oq_data,
	input wire logic ranging_error,
	input wire logic operation_summary,
	input wire logic message_available,
	input wire logic ques_power_summary
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	logic take;
	logic is_read;
	assign take = cmd_valid && cmd_ready;
	assign is_read = cmd.op inside {ops_pkg::OPS_READ_COND,
		ops_pkg::OPS_READ_RISE, ops_pkg::OPS_READ_FALL,
		ops_pkg::OPS_READ_EVENT, ops_pkg::OPS_READ_MASK};
	sequence s_read_take;
		take && is_read;
	endsequence
	sequence s_clear_oper;
		take && !ranging_error && (cmd.op == ops_pkg::OPS_CLEAR_STATUS
			|| (cmd.op == ops_pkg::OPS_READ_EVENT && !cmd.group));
	endsequence
	sequence s_mask_off(g);
		take && cmd.op == ops_pkg::OPS_WRITE_MASK && cmd.group == g
			&& cmd.data == 16'h0000;
	endsequence
	a_head_holds: assert property (
		oq_valid && !oq_ready |=> oq_valid && $stable(oq_data))
		else $error("Queue head changed before it was read.");
	a_read_answers: assert property (
		s_read_take |-> ##2 oq_valid ##[0:1] message_available)
		else $error("Query gave no answer in the queue.");
	a_avail_empty: assert property (
		!oq_valid |-> !message_available)
		else $error("Message available set with an empty queue.");
	a_ready_apart: assert property (
		!(cmd_ready && resp_ready))
		else $error("Command and response both accepted.");
	a_idle_no_cmd: assert property (
		cmd_ready |-> !oq_valid)
		else $error("Command accepted while data is unread.");
	// A write leaves the queue idle, so only a read holds commands off.
	a_cmd_gap: assert property (
		s_read_take |=> !cmd_ready [*3])
		else $error("Command ready while a read answer is pending.");
	// New edges may set events again one cycle later, so look at once.
	a_clear_oper: assert property (
		s_clear_oper |-> ##1 !operation_summary)
		else $error("Operation summary kept after clearing events.");
	a_mask_oper: assert property (
		s_mask_off(1'b0) |-> ##2 !operation_summary)
		else $error("Operation summary kept after zero mask.");
	a_mask_power: assert property (
		s_mask_off(1'b1) |-> ##2 !ques_power_summary)
		else $error("Power summary kept after zero mask.");
endmodule // ops_status_monitor

bind ops_status ops_status_monitor ops_status_monitor_inst (
	.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .cmd(cmd), .resp_ready(resp_ready),
	.oq_valid(oq_valid), .oq_ready(oq_ready), .oq_data(oq_data),
	.ranging_error(ranging_error),
	.operation_summary(operation_summary),
	.message_available(message_available),
	.ques_power_summary(ques_power_summary)
);

// [ops_ctrl_model.sv]
// Model of the remote controller that drains the output queue.
// Assumes the queue head stands until taken; delay sets its slowness.
module ops_ctrl_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] delay,
	input wire logic oq_valid,
	input wire logic [ops_pkg::REG_W-1:0] oq_data,
	output logic oq_ready,
	output logic got_stb,
	output logic [ops_pkg::REG_W-1:0] got_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_cnt;
	// A controller blocks on a read until data shows, then takes it once.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			oq_ready <= 1'b0;
			got_stb <= 1'b0;
			got_data <= 16'h0000;
			wait_cnt <= 4'h0;
		end else if (oq_valid && oq_ready) begin
			oq_ready <= 1'b0;
			got_stb <= 1'b1;
			got_data <= oq_data;
			wait_cnt <= 4'h0;
		end else begin
			got_stb <= 1'b0;
			if (oq_valid && wait_cnt >= delay) begin
				oq_ready <= 1'b1;
			end else if (oq_valid) begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule // ops_ctrl_model

// [test_operation_power_status_groups.sv]
// Self-checking bench for the status groups and output queue.
// Assumes package, design, checker and controller model compile first.
module test_operation_power_status_groups;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] MT [4] = '{12'h01F, 12'h01E, 12'h00A, 12'h009};
	localparam logic [15:0] PX [4] = '{16'h0004, 16'h0000, 16'h0000,
		16'h0002};
	logic core_clk, rst, cmd_valid, resp_valid, freq_uncal, ranging_error;
	logic cmd_ready, resp_ready, oq_valid, oq_ready, got_stb, refused;
	logic operation_summary, message_available, ques_power_summary;
	logic [15:0] resp_data, word, oq_data, got_data;
	logic [11:0] meas_temp, cal_temp;
	logic [7:0] src;
	logic [3:0] delay;
	ops_pkg::ops_request_t cmd;
	int mismatches, n_checks;
	int cycles = 0;
	ops_status ops_status_inst (.core_clk(core_clk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.resp_valid(resp_valid), .resp_ready(resp_ready),
		.resp_data(resp_data), .oq_valid(oq_valid), .oq_ready(oq_ready),
		.oq_data(oq_data), .prog_running(src[0]), .ext_timebase(src[1]),
		.primary_radio_summary(src[2]), .call_proc_summary(src[3]),
		.secondary_radio_summary(src[4]),
		.embedded_program_summary(src[5]), .measuring_summary(src[6]),
		.calibrating_summary(src[7]), .ranging_error(ranging_error),
		.meas_temp(meas_temp), .cal_temp(cal_temp), .freq_uncal(freq_uncal),
		.operation_summary(operation_summary),
		.message_available(message_available),
		.ques_power_summary(ques_power_summary));
	ops_ctrl_model ops_ctrl_model_inst (.core_clk(core_clk), .rst(rst),
		.delay(delay), .oq_valid(oq_valid), .oq_data(oq_data),
		.oq_ready(oq_ready), .got_stb(got_stb), .got_data(got_data));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic print_verdict();
		if (mismatches == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic send(input ops_pkg::ops_cmd_t op, input logic g,
		input logic [15:0] d);
		cmd_valid <= 1'b1;
		cmd <= '{op: op, group: g, data: d};
		do @(posedge core_clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		tick(1);
	endtask
	task automatic query(input ops_pkg::ops_cmd_t op, input logic g,
		input logic [15:0] exp);
		send(op, g, 16'h0000);
		do @(posedge core_clk); while (got_stb !== 1'b1);
		check(got_data, exp);
	endtask
	function automatic logic [15:0] oper_exp(input logic [7:0] s);
		logic [15:0] w;
		w = 16'h0000;
		w[ops_pkg::OPER_PROG_RUNNING] = s[0];
		w[ops_pkg::OPER_EXT_TIMEBASE] = s[1];
		w[ops_pkg::OPER_PRIMARY_RADIO] = s[2];
		w[ops_pkg::OPER_CALL_PROC] = s[3];
		w[ops_pkg::OPER_SECONDARY_RADIO] = s[4];
		w[ops_pkg::OPER_EMBEDDED_SUM] = s[5];
		w[ops_pkg::OPER_MEASURING] = s[6];
		w[ops_pkg::OPER_CALIBRATING] = s[7];
		return w;
	endfunction
	task automatic t_reset_values();
		for (int g = 0; g < 2; g++) begin
			query(ops_pkg::OPS_READ_RISE, g[0], 16'hFFFF);
			query(ops_pkg::OPS_READ_FALL, g[0], 16'h0000);
			query(ops_pkg::OPS_READ_MASK, g[0], 16'h0000);
			query(ops_pkg::OPS_READ_EVENT, g[0], 16'h0000);
		end
	endtask
	task automatic t_cond_map();
		for (int i = 0; i < 9; i++) begin
			src <= (i == 8) ? 8'hFF : 8'h01 << i;
			tick(3);
			query(ops_pkg::OPS_READ_COND, 1'b0, oper_exp(src));
			query(ops_pkg::OPS_READ_COND, 1'b0, oper_exp(src));
		end
		src <= 8'h00;
	endtask
	task automatic t_power();
		for (int i = 0; i < 4; i++) begin
			meas_temp <= MT[i];
			freq_uncal <= i[0];
			tick(3);
			query(ops_pkg::OPS_READ_COND, 1'b1, PX[i] | 16'(i[0]));
		end
	endtask
	task automatic t_events();
		send(ops_pkg::OPS_CLEAR_STATUS, 1'b0, 16'h0000);
		send(ops_pkg::OPS_WRITE_FALL, 1'b0, 16'h1000);
		query(ops_pkg::OPS_READ_FALL, 1'b0, 16'h1000);
		send(ops_pkg::OPS_WRITE_MASK, 1'b0, 16'h1004);
		query(ops_pkg::OPS_READ_MASK, 1'b0, 16'h1004);
		src <= 8'h02;
		tick(4);
		check(16'(operation_summary), 16'h0001);
		query(ops_pkg::OPS_READ_EVENT, 1'b0, 16'h1000);
		check(16'(operation_summary), 16'h0000);
		src <= 8'h00;
		tick(4);
		query(ops_pkg::OPS_READ_EVENT, 1'b0, 16'h1000);
		ranging_error <= 1'b1;
		tick(1);
		ranging_error <= 1'b0;
		tick(3);
		query(ops_pkg::OPS_READ_EVENT, 1'b0, 16'h0004);
		query(ops_pkg::OPS_READ_EVENT, 1'b0, 16'h0000);
		ranging_error <= 1'b1;
		tick(1);
		ranging_error <= 1'b0;
		tick(3);
		send(ops_pkg::OPS_CLEAR_STATUS, 1'b0, 16'h0000);
		check(16'(operation_summary), 16'h0000);
		ranging_error <= 1'b1;
		tick(1);
		ranging_error <= 1'b0;
		tick(3);
		send(ops_pkg::OPS_WRITE_MASK, 1'b0, 16'h0000);
		// The summary still follows the old mask for one more cycle.
		tick(1);
		check(16'(operation_summary), 16'h0000);
		send(ops_pkg::OPS_WRITE_MASK, 1'b1, 16'h0001);
		freq_uncal <= 1'b0;
		tick(2);
		freq_uncal <= 1'b1;
		tick(4);
		check(16'(ques_power_summary), 16'h0001);
		query(ops_pkg::OPS_READ_EVENT, 1'b1, 16'h0001);
		send(ops_pkg::OPS_WRITE_MASK, 1'b1, 16'h0000);
		// A rising filter without bit 0 must ignore the next rise there.
		send(ops_pkg::OPS_WRITE_RISE, 1'b1, 16'h0002);
		query(ops_pkg::OPS_READ_RISE, 1'b1, 16'h0002);
		freq_uncal <= 1'b0;
		tick(2);
		freq_uncal <= 1'b1;
		tick(3);
		query(ops_pkg::OPS_READ_EVENT, 1'b1, 16'h0000);
	endtask
	task automatic t_queue();
		delay <= 4'hF;
		refused = 1'b0;
		fork
			begin
				for (int i = 0; i < 20; i++) begin
					resp_valid <= 1'b1;
					resp_data <= 16'hA000 + 16'(i);
					do begin
						@(posedge core_clk);
						if (i > 0 && resp_ready !== 1'b1) refused = 1'b1;
					end while (resp_ready !== 1'b1);
				end
				resp_valid <= 1'b0;
			end
			for (int j = 0; j < 20; j++) begin
				do @(posedge core_clk); while (got_stb !== 1'b1);
				check(got_data, 16'hA000 + 16'(j));
				if (j == 10) check(16'(message_available), 16'h0001);
			end
		join
		check(16'(refused), 16'h0001);
		tick(4);
		check(16'(message_available), 16'h0000);
		delay <= 4'h0;
	endtask
	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		resp_valid = 1'b0;
		resp_data = 16'h0000;
		src = 8'h00;
		meas_temp = 12'h014;
		cal_temp = 12'h014;
		freq_uncal = 1'b0;
		ranging_error = 1'b0;
		delay = 4'h0;
		mismatches = 0;
		n_checks = 0;
		tick(12);
		rst <= 1'b0;
		tick(2);
		t_reset_values();
		t_cond_map();
		t_power();
		t_events();
		t_queue();
		print_verdict();
	end
endmodule // test_operation_power_status_groups
